// *** hw/eep_read_engine.sv ***
// eep_read_engine: read side of a 2-kbit two-wire serial eeprom target
// assumes scl, sda and strap pins are asynchronous to mclk and apb is on mclk
// Summary of operation
// - start, type 1010/1011, matching chip select and read bit get an ack.
// - reads ignore the write protect pin and the soft protect bit.
// - current read sends byte at counter, then counter increments and stays.
// - array counter wraps from last byte of last page to first byte.
// - one counter shared by array, ident page and serial block.
// - dummy write of address, repeated start, read select returns the byte.
// - each acked byte increments address and sends next; nack stops sending.
// - ident page read uses 1011, region bits 00, low four bits offset.
// - ident page reads wrap from last to first byte.
// - lock probe data byte acked when unlocked, nacked when locked.
// - start resets command logic, stop returns to standby.
// - soft protect read with region 11 returns seven zeros and protect bit.
// - further soft protect bytes repeat the same value.
// - serial read uses 1011, region bits 10, low bits select byte.
// - factory serial block is read only.
// - serial reads wrap after the sixteenth byte.
// - during a self-timed write no select byte is acknowledged.
// - protect bit resets to 0, array and ident page bytes to FFh.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module eep_read_engine
  import eep_pkg::*;
#(
  parameter logic [127:0] SERIAL_VALUE = 128'h0123456789ABCDEF0F1E2D3C4B5A6978,
  parameter int MEM_BYTES = 256,
  parameter int PAGE_BYTES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic [2:0] chipSelPins
);
  // serial value arbitrary default
  eep_apb_t bus;
  eep_link_t lk_r, lk_nxt;
  logic sclM_r, sclS_r, sclD_r, sdaM_r, sdaS_r, sdaD_r;
  logic [2:0] csM_r, csS_r;
  logic [7:0] mem_r [MEM_BYTES];
  logic [7:0] mem_nxt [MEM_BYTES];
  logic [7:0] idp_r [PAGE_BYTES];
  logic [7:0] idp_nxt [PAGE_BYTES];
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [8:0] memAddr_r, memAddr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, sdaOut_r;
  logic sclRise, sclFall, startDet, stopDet, wrBusy, soft_write_protect_bit, idLocked, selMatch, apbWr;
  logic [7:0] fetchByte;

  assign bus = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sdaOut = sdaOut_r;
  assign sdaOeN = lk_r.oeN;
  assign wrBusy = ctrl_r[CTRL_BUSY_POS];
  assign soft_write_protect_bit = ctrl_r[CTRL_SWP_POS];
  assign idLocked = ctrl_r[CTRL_LOCK_POS];

  function automatic logic [7:0] nextAddr(input logic [7:0] a, input eep_rgn_t r);
    case (r)
      RG_ARRAY: nextAddr = a + 8'h01;
      RG_SWP: nextAddr = a;
      default: nextAddr = {a[7:4], a[3:0] + 4'h1};
    endcase
  endfunction

  function automatic logic [7:0] serByte(input logic [3:0] i);
    serByte = SERIAL_VALUE[8'(127 - 8 * int'(i)) -: 8];
  endfunction

  // pin sampling and edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclM_r <= 1'b1;
      sclS_r <= 1'b1;
      sclD_r <= 1'b1;
      sdaM_r <= 1'b1;
      sdaS_r <= 1'b1;
      sdaD_r <= 1'b1;
      csM_r <= 3'h0;
      csS_r <= 3'h0;
    end else begin
      sclM_r <= scl;
      sclS_r <= sclM_r;
      sclD_r <= sclS_r;
      sdaM_r <= sdaIn;
      sdaS_r <= sdaM_r;
      sdaD_r <= sdaS_r;
      csM_r <= chipSelPins;
      csS_r <= csM_r;
    end
  end

  assign sclRise = sclS_r & ~sclD_r;
  assign sclFall = ~sclS_r & sclD_r;
  assign startDet = sclS_r & sclD_r & sdaD_r & ~sdaS_r;
  assign stopDet = sclS_r & sclD_r & ~sdaD_r & sdaS_r;
  assign selMatch = (lk_r.sh[7:4] == TYPE_ARRAY || lk_r.sh[7:4] == TYPE_SPECIAL)
    && lk_r.sh[3:1] == csS_r && !wrBusy;

  always_comb begin
    case (lk_r.rgn)
      RG_ARRAY: fetchByte = mem_r[lk_r.ctr];
      RG_SER: fetchByte = serByte(lk_r.ctr[3:0]);
      RG_SWP: fetchByte = {7'h00, soft_write_protect_bit};
      default: fetchByte = idp_r[lk_r.ctr[3:0]];
    endcase
  end

  always_comb begin
    lk_nxt = lk_r;
    if (startDet) begin
      lk_nxt.st = wrBusy ? LS_IDLE : LS_SEL;
      lk_nxt.bits = 4'h0;
      lk_nxt.oeN = 1'b1;
    end else if (stopDet) begin
      lk_nxt.st = LS_IDLE;
      lk_nxt.oeN = 1'b1;
    end else if (sclRise) begin
      case (lk_r.st)
        LS_SEL, LS_ADDR, LS_WDAT: begin
          lk_nxt.sh = {lk_r.sh[6:0], sdaS_r};
          lk_nxt.bits = lk_r.bits + 4'h1;
        end
        LS_TX: lk_nxt.bits = lk_r.bits + 4'h1;
        LS_TXACK: begin
          lk_nxt.mAck = ~sdaS_r;
          lk_nxt.ctr = nextAddr(lk_r.ctr, lk_r.rgn);
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (lk_r.st)
        LS_SEL: if (lk_r.bits == BITS_PER_BYTE) begin
          if (selMatch) begin
            lk_nxt.st = LS_ACKS;
            lk_nxt.oeN = 1'b0;
            lk_nxt.isRead = lk_r.sh[0];
            if (lk_r.sh[4] == 1'b0) begin
              lk_nxt.rgn = RG_ARRAY;
            end else if (!lk_r.sh[0] || lk_r.rgn == RG_ARRAY) begin
              lk_nxt.rgn = RG_ID;
            end
          end else begin
            lk_nxt.st = LS_IDLE;
          end
        end
        LS_ADDR: if (lk_r.bits == BITS_PER_BYTE) begin
          lk_nxt.st = LS_ACKA;
          lk_nxt.oeN = 1'b0;
          if (lk_r.rgn == RG_ARRAY) begin
            lk_nxt.ctr = lk_r.sh;
          end else begin
            lk_nxt.ctr = {4'h0, lk_r.sh[3:0]};
            case (lk_r.sh[7:6])
              RSEL_ID: lk_nxt.rgn = RG_ID;
              RSEL_LOCK: lk_nxt.rgn = RG_LOCK;
              RSEL_SER: lk_nxt.rgn = RG_SER;
              default: lk_nxt.rgn = RG_SWP;
            endcase
          end
        end
        LS_WDAT: if (lk_r.bits == BITS_PER_BYTE) begin
          lk_nxt.st = LS_ACKW;
          lk_nxt.oeN = (lk_r.rgn == RG_ID || lk_r.rgn == RG_LOCK) ? idLocked : 1'b0;
        end
        LS_ACKS: begin
          lk_nxt.bits = 4'h0;
          if (lk_r.isRead) begin
            lk_nxt.st = LS_TX;
            lk_nxt.tx = fetchByte;
            lk_nxt.oeN = fetchByte[7];
          end else begin
            lk_nxt.st = LS_ADDR;
            lk_nxt.oeN = 1'b1;
          end
        end
        LS_ACKA, LS_ACKW: begin
          lk_nxt.st = LS_WDAT;
          lk_nxt.bits = 4'h0;
          lk_nxt.oeN = 1'b1;
        end
        LS_TX: if (lk_r.bits == BITS_PER_BYTE) begin
          lk_nxt.st = LS_TXACK;
          lk_nxt.oeN = 1'b1;
        end else begin
          lk_nxt.tx = {lk_r.tx[6:0], 1'b0};
          lk_nxt.oeN = lk_r.tx[6];
        end
        LS_TXACK: if (lk_r.mAck) begin
          lk_nxt.st = LS_TX;
          lk_nxt.bits = 4'h0;
          lk_nxt.tx = fetchByte;
          lk_nxt.oeN = fetchByte[7];
        end else begin
          lk_nxt.st = LS_IDLE;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lk_r <= '{st: LS_IDLE, bits: 4'h0, sh: 8'h00, tx: 8'h00, isRead: 1'b0, rgn: RG_ARRAY,
        oeN: 1'b1, ctr: 8'h00, mAck: 1'b0};
      sdaOut_r <= 1'b0;
    end else begin
      lk_r <= lk_nxt;
      sdaOut_r <= 1'b0;
    end
  end

  // apb slave, one wait-free access phase
  assign apbWr = bus.sel & bus.en & pready_r & bus.wr;

  always_comb begin
    mem_nxt = mem_r;
    idp_nxt = idp_r;
    ctrl_nxt = ctrl_r;
    memAddr_nxt = memAddr_r;
    pready_nxt = bus.sel & ~bus.en;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (bus.sel & ~bus.en) begin
      prdata_nxt = 32'h0000_0000;
      case (bus.addr)
        OFS_CTRL: prdata_nxt = {29'h0, ctrl_r};
        OFS_STATUS: prdata_nxt = {20'h0, lk_r.st != LS_IDLE, lk_r.rgn, lk_r.ctr};
        OFS_MEMADDR: prdata_nxt = {23'h0, memAddr_r};
        OFS_MEMDATA: prdata_nxt = {24'h0, memAddr_r[8] ? idp_r[memAddr_r[3:0]] : mem_r[memAddr_r[7:0]]};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (apbWr) begin
      case (bus.addr)
        OFS_CTRL: ctrl_nxt = bus.wdata[2:0];
        OFS_MEMADDR: memAddr_nxt = bus.wdata[8:0];
        OFS_MEMDATA: begin
          if (memAddr_r[8]) begin
            idp_nxt[memAddr_r[3:0]] = bus.wdata[7:0];
          end else begin
            mem_nxt[memAddr_r[7:0]] = bus.wdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
      for (int i = 0; i < PAGE_BYTES; i++) begin
        idp_r[i] <= ERASED_BYTE;
      end
      ctrl_r <= CTRL_RESET;
      memAddr_r <= MEMADDR_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      idp_r <= idp_nxt;
      ctrl_r <= ctrl_nxt;
      memAddr_r <= memAddr_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence selDone;
    sclFall && !startDet && !stopDet && lk_r.st == LS_SEL && lk_r.bits == BITS_PER_BYTE;
  endsequence
  sequence nackSeen;
    sclFall && !startDet && !stopDet && lk_r.st == LS_TXACK && !lk_r.mAck;
  endsequence

  AST_SEL_ACK: assert property (selDone and selMatch |=> lk_r.st == LS_ACKS && !sdaOeN)
    else $error("matching select not acknowledged");
  AST_SEL_MISMATCH: assert property (selDone and !selMatch |=> lk_r.st == LS_IDLE && sdaOeN)
    else $error("mismatching select not ignored");
  AST_BUSY_SILENT: assert property (wrBusy && $past(wrBusy) |-> lk_r.st != LS_ACKS)
    else $error("select acknowledged during write cycle");
  AST_START_RESET: assert property (startDet && !wrBusy |=> lk_r.st == LS_SEL && lk_r.bits == 4'h0 && sdaOeN)
    else $error("start did not reset command logic");
  AST_NACK_STOPS: assert property (nackSeen |=> lk_r.st == LS_IDLE && sdaOeN)
    else $error("device kept sending after nack");
  AST_ARRAY_WRAP: assert property (sclRise && !startDet && !stopDet && lk_r.st == LS_TXACK
    && lk_r.rgn == RG_ARRAY && lk_r.ctr == 8'hFF |=> lk_r.ctr == 8'h00)
    else $error("array counter did not wrap");
  AST_PAGE_WRAP: assert property (sclRise && !startDet && !stopDet && lk_r.st == LS_TXACK
    && (lk_r.rgn == RG_ID || lk_r.rgn == RG_SER) |=> lk_r.ctr[3:0] == $past(lk_r.ctr[3:0]) + 4'h1
    && lk_r.ctr[7:4] == $past(lk_r.ctr[7:4]))
    else $error("page or serial counter did not wrap in block");
  AST_SWP_BYTE: assert property (lk_r.st == LS_TX && lk_r.bits == 4'h0 && lk_r.rgn == RG_SWP
    && $past(lk_r.st) != LS_TX |-> lk_r.tx == {7'h00, soft_write_protect_bit})
    else $error("protect byte has wrong value");
  AST_LOCK_PROBE: assert property (sclFall && !startDet && !stopDet && lk_r.st == LS_WDAT
    && lk_r.bits == BITS_PER_BYTE && lk_r.rgn == RG_ID |=> sdaOeN == $past(idLocked))
    else $error("lock probe answer wrong");
endmodule // eep_read_engine

// *** hw/eep_pkg.sv ***
// eep_pkg: constants and types for the serial eeprom read engine
// assumes an apb master on mclk and an i2c master on scl/sda pins
package eep_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MEMADDR = 8'h08;
  localparam logic [7:0] OFS_MEMDATA = 8'h0C;
  localparam int CTRL_BUSY_POS = 0;
  localparam int CTRL_SWP_POS = 1;
  localparam int CTRL_LOCK_POS = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [8:0] MEMADDR_RESET = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_SPECIAL = 4'hB;
  localparam logic [1:0] RSEL_ID = 2'h0;
  localparam logic [1:0] RSEL_LOCK = 2'h1;
  localparam logic [1:0] RSEL_SER = 2'h2;
  localparam logic [1:0] RSEL_SWP = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {RG_ARRAY, RG_ID, RG_LOCK, RG_SER, RG_SWP} eep_rgn_t;
  typedef enum logic [3:0] {LS_IDLE, LS_SEL, LS_ACKS, LS_ADDR, LS_ACKA, LS_WDAT, LS_ACKW,
    LS_TX, LS_TXACK} eep_lst_t;

  typedef struct packed {
    eep_lst_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] tx;
    logic isRead;
    eep_rgn_t rgn;
    logic oeN;
    logic [7:0] ctr;
    logic mAck;
  } eep_link_t;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } eep_apb_t;
endpackage

// *** test/eep_i2c_master.sv ***
// eep_i2c_master: behavioural two-wire bus master for the bench
// assumes the bench builds a pulled-up sda wire from all enables
`timescale 1ns/10ps
module eep_i2c_master (
  output logic scl,
  output logic sdaOeN,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sdaOeN = 1'b1;
  end
  task automatic start();
    #12 sdaOeN = 1'b1;
    #12 scl = 1'b1;
    #24 sdaOeN = 1'b0;
    #24 scl = 1'b0;
  endtask
  task automatic stop();
    #12 sdaOeN = 1'b0;
    #12 scl = 1'b1;
    #24 sdaOeN = 1'b1;
    #24;
  endtask
  task automatic bitx(input logic b, output logic s);
    #12 sdaOeN = b;
    #12 scl = 1'b1;
    #24 s = sda;
    scl = 1'b0;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  // ack asks for more, nack ends
  task automatic rdByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(~ack, s);
  endtask
endmodule // eep_i2c_master

// *** test/eep_read_engine_tb.sv ***
// eep_read_engine_tb: apb and two-wire scenarios with self checks
// assumes a pulled-up sda and strap pins tied to 3'h5
`timescale 1ns/10ps
module eep_read_engine_tb;
  import eep_pkg::*;
  localparam logic [127:0] SER = 128'h00112233445566778899AABBCCDDEEFF;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sdaOut, sdaOeN, scl, mOeN;
  wire logic sda = (sdaOeN | sdaOut) & mOeN;
  int n_errors = 0;
  int cmp_count = 0;
  always #2.5 mclk = ~mclk;
  eep_read_engine #(.SERIAL_VALUE(SER), .MEM_BYTES(256), .PAGE_BYTES(16)) dut (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .chipSelPins(3'h5));
  eep_i2c_master mst (.scl(scl), .sdaOeN(mOeN), .sda(sda));
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 1, 0);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r & m);
  endtask
  task automatic sel(input logic [3:0] t, input logic [2:0] cs, input logic rw, input logic x);
    logic k;
    mst.start();
    mst.wrByte({t, cs, rw}, k);
    chk("select ack", {31'h0, x}, {31'h0, k});
  endtask
  task automatic rread(input logic [3:0] t, input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic k;
    logic [7:0] d;
    sel(t, 3'h5, 1'b0, 1'b1);
    mst.wrByte(a, k);
    chk("addr ack", 1, {31'h0, k});
    sel(t, 3'h5, 1'b1, 1'b1);
    mst.rdByte(1'b1, d);
    chk("first byte", {24'h0, e0}, {24'h0, d});
    mst.rdByte(1'b0, d);
    chk("second byte", {24'h0, e1}, {24'h0, d});
    mst.stop();
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rdchk("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk("array byte", OFS_MEMDATA, 32'hFFFFFFFF, 32'hFF);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", 1, {31'h0, e});
  endtask
  task automatic t_array();
    logic [7:0] d;
    wr(OFS_MEMADDR, 32'hFF);
    wr(OFS_MEMDATA, 32'h5A);
    wr(OFS_MEMADDR, 32'h00);
    wr(OFS_MEMDATA, 32'hA5);
    wr(OFS_CTRL, 32'h2);
    rread(TYPE_ARRAY, 8'hFF, 8'h5A, 8'hA5);
    sel(TYPE_ARRAY, 3'h5, 1'b1, 1'b1);
    mst.rdByte(1'b0, d);
    mst.stop();
    chk("current byte", 32'hFF, {24'h0, d});
    rdchk("counter", OFS_STATUS, 32'hFF, 32'h02);
  endtask
  task automatic t_special();
    wr(OFS_MEMADDR, 32'h10F);
    wr(OFS_MEMDATA, 32'h3C);
    rread(TYPE_SPECIAL, 8'h3F, 8'h3C, 8'hFF);
    rdchk("shared counter", OFS_STATUS, 32'hFF, 32'h01);
    rread(TYPE_SPECIAL, 8'hBF, SER[7:0], SER[127:120]);
    rread(TYPE_SPECIAL, 8'hC5, 8'h01, 8'h01);
  endtask
  task automatic t_serial();
    logic k;
    logic [7:0] d;
    sel(TYPE_SPECIAL, 3'h5, 1'b0, 1'b1);
    mst.wrByte(8'h80, k);
    chk("serial addr ack", 1, {31'h0, k});
    sel(TYPE_SPECIAL, 3'h5, 1'b1, 1'b1);
    for (int i = 0; i <= 16; i++) begin
      mst.rdByte(i < 16, d);
      chk("serial byte", {24'h0, SER[127 - 8 * (i % 16) -: 8]}, {24'h0, d});
    end
    mst.stop();
  endtask
  task automatic t_lock(input logic lk);
    logic k;
    wr(OFS_CTRL, {29'h0, lk, 2'h0});
    sel(TYPE_SPECIAL, 3'h5, 1'b0, 1'b1);
    mst.wrByte(8'h00, k);
    chk("probe addr ack", 1, {31'h0, k});
    mst.wrByte(8'h00, k);
    chk("lock probe ack", {31'h0, ~lk}, {31'h0, k});
    mst.start();
    mst.stop();
  endtask
  task automatic t_refuse();
    logic [7:0] d;
    sel(TYPE_ARRAY, 3'h2, 1'b1, 1'b0);
    mst.stop();
    wr(OFS_CTRL, 32'h1);
    sel(TYPE_ARRAY, 3'h5, 1'b1, 1'b0);
    mst.stop();
    wr(OFS_CTRL, 32'h0);
    sel(TYPE_ARRAY, 3'h5, 1'b1, 1'b1);
    mst.rdByte(1'b0, d);
    mst.stop();
    chk("counter after probe", 32'hA5, {24'h0, d});
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_reset();
    t_array();
    t_special();
    t_serial();
    t_lock(1'b0);
    t_lock(1'b1);
    t_refuse();
    print_verdict();
  end
endmodule // eep_read_engine_tb
